// File: hw/srg_flag.sv
// one sticky status flag with set priority over clear
`timescale 1ns/10ps
module srg_flag (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic set_in,
    input wire logic clr_in,
    output logic flag_out
);
    // set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            flag_out <= 1'b0;
        end else if (set_in) begin
            flag_out <= 1'b1;
        end else if (clr_in) begin
            flag_out <= 1'b0;
        end
    end
endmodule

// File: hw/srg_gate.sv
// secure remap gate: remaps channel accesses onto a master port
// What this block does
// - configuration via config ports, remap targets via slave port in setup mode; accesses via slave/master
// - each access remapped via its target and forwarded when unlocked
// - halts with clock stopped and resumes with state kept
// - keeps running normally while the cpu is held by a debugger
// - enable pulse enables gate and sets enabled flag; disable clears it
// - one address reaches channel normally, remap target in setup
// - setup enter and exit pulses select setup mode
// - targets below 0xFFFC0000 refused and raise address error flag
// - open mode makes enabled channels always accessible
// - keyed unlock opens channel for window + 1 cycles or one access
// - only one channel unlocked; new unlock relocks the old one
// - access to locked channel aborted and sets failure flag
// - unlock while any error flag set is aborted, sets unlock error
// - interrupt when flag and mask both set; set/clear mask pulses
// - flags stay set until cleared by a flag-clear write
// - wrong key with no error flag set sets bad key flag and keeps all locked
// - reading the unlock port sets unlock read flag
// - success sets success flag; idle window expiry relocks, sets expiry
// - bus error answers when response on, master error sets flag
// - response-off pulse stops bus errors; zero does nothing
// - high enable bit n enables channel n+32
`timescale 1ns/10ps
`include "srg_params.svh"
module srg_gate #(
    parameter int CHANNELS = `SRG_CHAN_NUM
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic gate_enable_in,
    input wire logic gate_disable_in,
    input wire logic setup_enter_in,
    input wire logic setup_exit_in,
    input wire logic bus_error_response_on_in,
    input wire logic bus_error_response_off_in,
    input wire logic open_mode_in,
    input wire logic [`SRG_UNLOCK_WINDOW_CYCLES_W-1:0] unlock_window_cycles_in,
    input wire logic [`SRG_KEY_W-1:0] unlock_key_in,
    input wire logic [31:0] channel_enable_low_in,
    input wire logic [30:0] channel_enable_high_in,
    input wire logic [`SRG_FLAG_W-1:0] interrupt_mask_set_in,
    input wire logic [`SRG_FLAG_W-1:0] interrupt_mask_clear_in,
    input wire logic [`SRG_FLAG_W-1:0] interrupt_flag_clear_in,
    input wire srg_pkg::srg_req_t sreq_in,
    input wire logic mready_in,
    input wire logic merror_in,
    input wire logic [31:0] mrdata_in,
    output srg_pkg::srg_mreq_t mreq_out,
    output logic sdone_out,
    output logic serror_out,
    output logic [31:0] srdata_out,
    output logic [`SRG_FLAG_W-1:0] status_reg_out,
    output logic [`SRG_FLAG_W-1:0] interrupt_mask_out,
    output logic gate_enabled_out,
    output logic setup_mode_out,
    output logic idle_out,
    output logic irq_out
);
    // refuse channel counts that the six-bit channel field cannot serve
    if (CHANNELS < 1 || CHANNELS > 63) begin : g_bad_channels
        $error("CHANNELS must be 1..63");
    end

    srg_pkg::srg_state_t state_reg;
    logic [31:0] remap_target_reg [CHANNELS];
    logic berr_on_reg;
    logic unlocked_reg;
    logic [5:0] unlocked_chan_reg;
    logic [`SRG_UNLOCK_WINDOW_CYCLES_W-1:0] window_reg;
    logic [`SRG_FLAG_W-1:0] flag_set;
    logic [`SRG_FLAG_W-1:0] flags;
    logic [5:0] chan;
    logic is_unlock;
    logic chan_ok;
    logic chan_en;
    logic take;
    logic [62:0] en_all;
    logic unl_write;
    logic key_ok;
    logic err_pending;
    logic acc_ok;
    logic acc_bad;
    logic expire;

    // decode the incoming slave request; the offset is a word index * 4
    // accesses via slave port
    assign chan = sreq_in.offset[7:2];
    assign is_unlock = sreq_in.offset == `SRG_UNLOCK_OFFS;
    assign chan_ok = !is_unlock && (chan < 6'(CHANNELS));
    assign en_all = {channel_enable_high_in, channel_enable_low_in};
    // high enable bits map to channels 32 and up
    assign chan_en = en_all[chan];
    assign take = sreq_in.valid && state_reg == srg_pkg::SRG_IDLE &&
                  gate_enabled_out;
    assign unl_write = take && is_unlock && sreq_in.write;
    assign key_ok = sreq_in.wdata[15:8] == unlock_key_in;
    assign err_pending = |(flags & `SRG_ERR_MASK);
    // open mode skips the lock; disabled counts as locked
    assign acc_ok = take && chan_ok && !setup_mode_out && chan_en &&
                    (open_mode_in ||
                     (unlocked_reg && unlocked_chan_reg == chan));
    // locked or disabled channel access is aborted
    assign acc_bad = take && chan_ok && !setup_mode_out && !acc_ok;
    assign expire = unlocked_reg && window_reg == '0 &&
                    !(acc_ok && unlocked_chan_reg == chan) && !unl_write;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            gate_enabled_out <= 1'b0;
        end else if (gate_enable_in) begin
            gate_enabled_out <= 1'b1;
        end else if (gate_disable_in) begin
            gate_enabled_out <= 1'b0;
        end
    end

    // setup mode flag; it steers the shared address
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            setup_mode_out <= 1'b0;
        end else if (setup_enter_in) begin
            setup_mode_out <= 1'b1;
        end else if (setup_exit_in) begin
            setup_mode_out <= 1'b0;
        end
    end

    // bus error response on/off, zero writes change nothing
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            berr_on_reg <= 1'b0;
        end else if (bus_error_response_on_in) begin
            berr_on_reg <= 1'b1;
        end else if (bus_error_response_off_in) begin
            berr_on_reg <= 1'b0;
        end
    end

    // remap targets written in setup mode, low addresses refused
    always_ff @(posedge clk_in) begin
        if (take && chan_ok && setup_mode_out && sreq_in.write &&
            sreq_in.wdata >= `SRG_RTR_MIN) begin
            remap_target_reg[chan] <= sreq_in.wdata;
        end
    end

    // keyed unlock opens a window; replaces any other
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            unlocked_reg <= 1'b0;
            unlocked_chan_reg <= 6'h00;
            window_reg <= '0;
        end else if (unl_write) begin
            // abort when errors pend; wrong key relocks all
            unlocked_reg <= !err_pending && key_ok &&
                            sreq_in.wdata[5:0] < 6'(CHANNELS);
            unlocked_chan_reg <= sreq_in.wdata[5:0];
            window_reg <= unlock_window_cycles_in;
        end else if (acc_ok && unlocked_reg && unlocked_chan_reg == chan) begin
            // one access consumes the unlock
            unlocked_reg <= 1'b0;
        end else if (expire) begin
            unlocked_reg <= 1'b0;
        end else if (unlocked_reg) begin
            window_reg <= window_reg - 1'b1;
        end
    end

    // access engine: forward remapped transfer, return answer
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg <= srg_pkg::SRG_IDLE;
            mreq_out <= '0;
            sdone_out <= 1'b0;
            serror_out <= 1'b0;
            srdata_out <= 32'h00000000;
        end else begin
            sdone_out <= 1'b0;
            serror_out <= 1'b0;
            case (state_reg)
                srg_pkg::SRG_IDLE: begin
                    if (acc_ok) begin
                        mreq_out.valid <= 1'b1;
                        mreq_out.write <= sreq_in.write;
                        mreq_out.addr <= remap_target_reg[chan];
                        mreq_out.wdata <= sreq_in.wdata;
                        state_reg <= srg_pkg::SRG_MSTR;
                    end else if (take) begin
                        // unlock read and locked access may error
                        sdone_out <= 1'b1;
                        serror_out <= berr_on_reg &&
                                      (acc_bad ||
                                       (is_unlock && !sreq_in.write));
                        srdata_out <= (take && chan_ok && setup_mode_out)
                                      ? remap_target_reg[chan]
                                      : 32'h00000000;
                    end
                end
                srg_pkg::SRG_MSTR: begin
                    if (mready_in) begin
                        mreq_out.valid <= 1'b0;
                        sdone_out <= 1'b1;
                        serror_out <= berr_on_reg && merror_in;
                        srdata_out <= mrdata_in;
                        state_reg <= srg_pkg::SRG_DONE;
                    end
                end
                srg_pkg::SRG_DONE: begin
                    state_reg <= srg_pkg::SRG_IDLE;
                end
                default: begin
                    state_reg <= srg_pkg::SRG_IDLE;
                end
            endcase
        end
    end

    // status event sources
    always_comb begin
        flag_set = '0;
        flag_set[`SRG_F_EXP] = expire;
        flag_set[`SRG_F_CAU] = acc_bad;
        flag_set[`SRG_F_UNLOCK_READ_FLAG] = take && is_unlock && !sreq_in.write;
        flag_set[`SRG_F_BAD_KEY_FLAG] = unl_write && !err_pending && !key_ok;
        flag_set[`SRG_F_UNLOCK_ERROR_FLAG] = unl_write && err_pending;
        flag_set[`SRG_F_MBERR] = state_reg == srg_pkg::SRG_MSTR &&
                                  mready_in && merror_in;
        flag_set[`SRG_F_REMAP_ADDRESS_ERROR_FLAG] = take && chan_ok && setup_mode_out &&
                                   sreq_in.write &&
                                   sreq_in.wdata < `SRG_RTR_MIN;
        flag_set[`SRG_F_CAS] = state_reg == srg_pkg::SRG_MSTR &&
                                mready_in && !merror_in;
    end

    // sticky flags, cleared by flag-clear pulses
    genvar gi;
    generate
        for (gi = 0; gi < `SRG_FLAG_W; gi++) begin : g_flag
            srg_flag u_flag (
                .clk_in(clk_in),
                .srst_in(srst_in),
                .set_in(flag_set[gi]),
                .clr_in(interrupt_flag_clear_in[gi]),
                .flag_out(flags[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            interrupt_mask_out <= `SRG_FLAG_RESET;
            irq_out <= 1'b0;
            status_reg_out <= `SRG_FLAG_RESET;
            idle_out <= 1'b1;
        end else begin
            interrupt_mask_out <= (interrupt_mask_out |
                                   interrupt_mask_set_in) &
                                  ~interrupt_mask_clear_in;
            irq_out <= |(flags & interrupt_mask_out);
            status_reg_out <= flags;
            idle_out <= state_reg == srg_pkg::SRG_IDLE && !acc_ok;
        end
    end

    a_master_hold: assert property (
        @(posedge clk_in) disable iff (srst_in)
        mreq_out.valid && !mready_in |=> mreq_out.valid && $stable(mreq_out))
        else $error("master request dropped early");
    a_locked_abort: assert property (
        @(posedge clk_in) disable iff (srst_in)
        acc_bad |=> !mreq_out.valid ##1 flags[`SRG_F_CAU])
        else $error("locked access not aborted");
    a_single_unlock: assert property (
        @(posedge clk_in) disable iff (srst_in)
        unl_write && !err_pending && key_ok &&
        sreq_in.wdata[5:0] < 6'(CHANNELS)
        |=> unlocked_reg && unlocked_chan_reg == $past(sreq_in.wdata[5:0]))
        else $error("unlock not taken");
    a_unlock_err: assert property (
        @(posedge clk_in) disable iff (srst_in)
        unl_write && err_pending |=> !unlocked_reg ##1 flags[`SRG_F_UNLOCK_ERROR_FLAG])
        else $error("unlock with errors not aborted");
    a_bad_key: assert property (
        @(posedge clk_in) disable iff (srst_in)
        unl_write && !key_ok |=> !unlocked_reg)
        else $error("bad key unlocked");
    a_unlock_read: assert property (
        @(posedge clk_in) disable iff (srst_in)
        take && is_unlock && !sreq_in.write |-> ##2 flags[`SRG_F_UNLOCK_READ_FLAG])
        else $error("unlock read not flagged");
    a_irq_mask: assert property (
        @(posedge clk_in) disable iff (srst_in)
        irq_out |-> $past(|(flags & interrupt_mask_out)))
        else $error("irq without masked flag");
    a_enable_flag: assert property (
        @(posedge clk_in) disable iff (srst_in)
        gate_enable_in |=> gate_enabled_out)
        else $error("enable not set");
    // low target not stored; unwritten targets may be unknown
    a_rtr_range: assert property (
        @(posedge clk_in) disable iff (srst_in)
        flag_set[`SRG_F_REMAP_ADDRESS_ERROR_FLAG] |=>
        remap_target_reg[$past(chan)] === $past(remap_target_reg[chan]))
        else $error("low target stored");
    c_remap: cover property (@(posedge clk_in) acc_ok ##[1:8] sdone_out);
    c_expire: cover property (@(posedge clk_in) expire);
    c_berr: cover property (@(posedge clk_in) serror_out);
endmodule

// File: hw/srg_params.svh
// constants for the secure remap gate: field positions, limits, resets
`ifndef SRG_PARAMS_SVH
`define SRG_PARAMS_SVH
`define SRG_CHAN_NUM 63
`define SRG_RTR_MIN 32'hFFFC0000
`define SRG_UNLOCK_OFFS 8'hFC
`define SRG_KEY_W 8
`define SRG_UNLOCK_WINDOW_CYCLES_W 8
`define SRG_FLAG_W 8
`define SRG_F_EXP 0
`define SRG_F_CAU 1
`define SRG_F_UNLOCK_READ_FLAG 2
`define SRG_F_BAD_KEY_FLAG 3
`define SRG_F_UNLOCK_ERROR_FLAG 4
`define SRG_F_MBERR 5
`define SRG_F_REMAP_ADDRESS_ERROR_FLAG 6
`define SRG_F_CAS 7
`define SRG_ERR_MASK 8'h7F
`define SRG_FLAG_RESET 8'h00
`endif

// File: hw/srg_pkg.sv
// types shared by the secure remap gate
package srg_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] offset;
        logic [31:0] wdata;
    } srg_req_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } srg_mreq_t;
    typedef enum logic [1:0] {
        SRG_IDLE = 2'b00,
        SRG_MSTR = 2'b01,
        SRG_DONE = 2'b11
    } srg_state_t;
endpackage

// File: sim/srg_gate_tb_top.sv
// self-checking bench for the secure remap gate
`timescale 1ns/10ps
`include "srg_params.svh"
`define CHK(a, b) begin \
    tests_run++; \
    if ((a) !== (b)) begin \
        errors++; \
        $display("CHECK FAILED %0t got %0h exp %0h", $time, a, b); \
    end \
end
module srg_gate_tb_top;
    localparam logic [31:0] T1 = 32'hFFFC0010;
    localparam logic [31:0] TERR = 32'hFFFC0F00;
    localparam logic [7:0] KEY = 8'h3C;
    logic clk_in = 1'b0, srst_in = 1'b1;
    logic gate_enable_in = 0, gate_disable_in = 0;
    logic setup_enter_in = 0, setup_exit_in = 0, open_mode_in = 0;
    logic bus_error_response_on_in = 0, bus_error_response_off_in = 0;
    logic [7:0] unlock_window_cycles_in = 8'h04, unlock_key_in = KEY;
    logic [31:0] channel_enable_low_in = 32'h0;
    logic [30:0] channel_enable_high_in = 31'h0;
    logic [7:0] interrupt_mask_set_in = 0, interrupt_mask_clear_in = 0;
    logic [7:0] interrupt_flag_clear_in = 0;
    srg_pkg::srg_req_t sreq_in = '0;
    srg_pkg::srg_mreq_t mreq_out;
    logic mready_in, merror_in, sdone_out, serror_out, gate_enabled_out;
    logic setup_mode_out, idle_out, irq_out;
    logic [31:0] mrdata_in, srdata_out, last_addr;
    logic [31:0] last_wdata;
    logic last_wr;
    logic [7:0] status_reg_out, interrupt_mask_out;
    logic [3:0] delay = 4'h0;
    int errors = 0, tests_run = 0, cycles = 0;
    srg_gate u_srg_gate (.clk_in, .srst_in, .gate_enable_in, .gate_disable_in,
        .setup_enter_in, .setup_exit_in, .bus_error_response_on_in,
        .bus_error_response_off_in, .open_mode_in, .unlock_window_cycles_in,
        .unlock_key_in, .channel_enable_low_in, .channel_enable_high_in,
        .interrupt_mask_set_in, .interrupt_mask_clear_in,
        .interrupt_flag_clear_in, .sreq_in, .mready_in, .merror_in,
        .mrdata_in, .mreq_out, .sdone_out, .serror_out, .srdata_out,
        .status_reg_out, .interrupt_mask_out, .gate_enabled_out,
        .setup_mode_out, .idle_out, .irq_out);
    srg_slave_model u_srg_slave_model (.clk_in, .mreq_in(mreq_out),
        .delay_in(delay), .mready_out(mready_in), .merror_out(merror_in),
        .mrdata_out(mrdata_in));
    // clock never stops, so no access is left pending
    // free running clock
    initial forever #50 clk_in = ~clk_in;
    // cut a hang short after far more cycles than the tests need
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            end_of_test();
        end
        if (mreq_out.valid) begin
            last_addr <= mreq_out.addr;
            last_wr <= mreq_out.write;
            last_wdata <= mreq_out.wdata;
        end
    end
    task automatic step();
        @(posedge clk_in);
        #1;
    endtask
    // one slave request held until done, then wait for idle
    // idle before checking
    task automatic access(input logic wr, input logic [7:0] off,
            input logic [31:0] wd, input logic exp_err, input logic [31:0] rd);
        int i;
        sreq_in = '{1'b1, wr, off, wd};
        for (i = 0; i < 40 && sdone_out !== 1'b1; i++) step();
        `CHK(sdone_out, 1'b1)
        `CHK(serror_out, exp_err)
        if (!wr && !exp_err) `CHK(srdata_out, rd)
        sreq_in = '0;
        step();
        for (i = 0; i < 10 && idle_out !== 1'b1; i++) step();
        `CHK(idle_out, 1'b1)
        step();
    endtask
    // keyed unlock write, key in [15:8], channel in [5:0]
    // unlock precedes access
    task automatic unl(input logic [5:0] ch, input logic [7:0] k);
        access(1'b1, 8'hFC, {16'h0, k, 2'b00, ch}, 1'b0, 32'h0);
    endtask
    task automatic clr();
        interrupt_flag_clear_in = 8'hFF;
        step();
        interrupt_flag_clear_in = 8'h00;
        step();
    endtask
    task automatic t_setup();
        `CHK(status_reg_out, 8'h00)
        `CHK(idle_out, 1'b1)
        `CHK(interrupt_mask_out, 8'h00)
        `CHK(irq_out, 1'b0)
        gate_enable_in = 1; setup_enter_in = 1; step();
        gate_enable_in = 0; setup_enter_in = 0; step();
        `CHK(gate_enabled_out, 1'b1)
        `CHK(setup_mode_out, 1'b1)
        access(1, 8'h04, T1, 0, 0);
        access(1, 8'h08, TERR, 0, 0);
        access(1, 8'h84, T1 + 32'h4, 0, 0);
        `CHK(status_reg_out, 8'h00)
        access(1, 8'h0C, 32'hFFFBFFFC, 0, 0);
        `CHK(status_reg_out, 8'h40)
        access(0, 8'h04, 0, 0, T1);
        clr();
        setup_exit_in = 1; step(); setup_exit_in = 0; step();
        `CHK(setup_mode_out, 1'b0)
        channel_enable_low_in = 32'h6;
        channel_enable_high_in = 31'h2;
        $display("test setup done");
    endtask
    task automatic t_open();
        open_mode_in = 1;
        access(0, 8'h04, 0, 0, T1 ^ 32'h5A5A5A5A);
        `CHK(last_addr, T1)
        `CHK(last_wr, 1'b0)
        `CHK(status_reg_out, 8'h80)
        delay = 4'h3;
        access(1, 8'h84, 32'h1234, 0, 0);
        `CHK(last_addr, T1 + 32'h4)
        `CHK(last_wr, 1'b1)
        `CHK(last_wdata, 32'h00001234)
        access(0, 8'h10, 0, 0, 0);
        `CHK(status_reg_out, 8'h82)
        clr();
        bus_error_response_on_in = 1; step();
        bus_error_response_on_in = 0; step();
        access(0, 8'h08, 0, 1, 0);
        `CHK(status_reg_out[`SRG_F_MBERR], 1'b1)
        clr();
        $display("test open done");
    endtask
    task automatic t_lock();
        open_mode_in = 0;
        interrupt_mask_set_in = 8'h02;
        step();
        interrupt_mask_set_in = 8'h00;
        `CHK(interrupt_mask_out, 8'h02)
        access(0, 8'h04, 0, 1, 0);
        `CHK(status_reg_out, 8'h02)
        `CHK(irq_out, 1'b1)
        repeat (5) step();
        `CHK(status_reg_out, 8'h02)
        unl(6'd1, KEY);
        `CHK(status_reg_out, 8'h12)
        interrupt_mask_clear_in = 8'h02; step(); interrupt_mask_clear_in = 0;
        step();
        `CHK(irq_out, 1'b0)
        `CHK(interrupt_mask_out, 8'h00)
        clr();
        unl(6'd1, KEY ^ 8'h01);
        access(0, 8'h04, 0, 1, 0);
        `CHK(status_reg_out, 8'h0A)
        clr();
        access(0, 8'hFC, 0, 1, 0);
        `CHK(status_reg_out, 8'h04)
        clr();
        unl(6'd1, KEY);
        access(0, 8'h04, 0, 0, T1 ^ 32'h5A5A5A5A);
        access(0, 8'h04, 0, 1, 0);
        clr();
        unl(6'd1, KEY);
        unl(6'd33, KEY);
        access(0, 8'h04, 0, 1, 0);
        clr();
        unl(6'd1, KEY);
        // expiry lands window + 1 cycles after the unlock, not earlier
        repeat (3) step();
        `CHK(status_reg_out, 8'h00)
        repeat (5) step();
        `CHK(status_reg_out, 8'h01)
        clr();
        bus_error_response_off_in = 1; step();
        bus_error_response_off_in = 0; step();
        access(0, 8'h04, 0, 0, 0);
        `CHK(status_reg_out, 8'h02)
        gate_disable_in = 1; step(); gate_disable_in = 0; step();
        `CHK(gate_enabled_out, 1'b0)
        $display("test lock done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (3) step();
        srst_in = 1'b0;
        t_setup();
        t_open();
        t_lock();
        end_of_test();
    end
endmodule

// File: sim/srg_slave_model.sv
// far-side slave model answering the gate's master port
`timescale 1ns/10ps
module srg_slave_model #(
    parameter logic [31:0] ERR_ADDR = 32'hFFFC0F00
) (
    input wire logic clk_in,
    input wire srg_pkg::srg_mreq_t mreq_in,
    input wire logic [3:0] delay_in,
    output logic mready_out,
    output logic merror_out,
    output logic [31:0] mrdata_out
);
    logic [3:0] wait_reg = 4'h0;
    initial mready_out = 1'b0;
    initial merror_out = 1'b0;
    initial mrdata_out = 32'h0;
    // one-cycle answer after delay_in; idle data toggles so no stale word
    always @(posedge clk_in) begin
        if (mready_out) begin
            mready_out <= 1'b0;
            merror_out <= 1'b0;
            wait_reg <= 4'h0;
            mrdata_out <= ~mrdata_out;
        end else if (mreq_in.valid && wait_reg == delay_in) begin
            mready_out <= 1'b1;
            merror_out <= (mreq_in.addr == ERR_ADDR);
            mrdata_out <= mreq_in.addr ^ 32'h5A5A5A5A;
        end else begin
            wait_reg <= mreq_in.valid ? wait_reg + 4'h1 : 4'h0;
            mrdata_out <= ~mrdata_out;
        end
    end
endmodule
